// [rtl/fcs_ctrl.sv]
// Host controller for a parallel NOR flash: command sequences, polling.
// Assumes an AHB-Lite master and a word-mode flash on the pins.
//
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "fcs_params.svh"

module fcs_ctrl (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  // Flash pins
  output logic [17:0] FL_ADDR,
  output logic [15:0] FL_DQ_O,
  output logic FL_DQ_OE,
  input wire logic [15:0] FL_DQ_I,
  output logic FL_CE_N,
  output logic FL_WE_N,
  output logic FL_OE_N,
  input wire logic FL_READY_BUSY_N
);
  import fcs_pkg::*;

  // ****************************************
  // Bus side registers
  // ****************************************
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_off_r, wr_off_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic [17:0] addr_r, addr_nxt;
  logic [15:0] wdat_r, wdat_nxt;
  logic acc, go;
  fcs_op_t wop;
  logic [31:0] stat, rd_mux;

  // ****************************************
  // Sequencer state
  // ****************************************
  fcs_st_t st_r, st_nxt;
  fcs_op_t op_r, op_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic chk_r, chk_nxt, done_r, done_nxt, fail_r, fail_nxt;
  logic err_r, err_nxt, byp_r, byp_nxt, idm_r, idm_nxt;
  logic susp_r, susp_nxt;
  logic [15:0] rdat_r, rdat_nxt;
  logic s_wr, s_last, poll_op, poll_exp;
  logic [17:0] s_addr;
  logic [15:0] s_data;
  logic cyc_go, cyc_wr, cyc_done;
  logic [17:0] cyc_addr;
  logic [15:0] cyc_data, cyc_rdata;

  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = hrdata_r;
  assign acc = HSEL && HTRANS[1] && HREADY;
  assign wop = fcs_op_t'(HWDATA[3:0]);
  assign go = wr_pend_r && (wr_off_r == `FCS_OFF_CTRL) && (st_r == S_IDLE);

  always_comb begin
    stat = 32'h0000_0000;
    stat[`FCS_ST_BUSY] = (st_r != S_IDLE);
    stat[`FCS_ST_DONE] = done_r;
    stat[`FCS_ST_FAIL] = fail_r;
    stat[`FCS_ST_ERR] = err_r;
    stat[`FCS_ST_RDY] = FL_READY_BUSY_N;
    stat[`FCS_ST_BYP] = byp_r;
    stat[`FCS_ST_IDM] = idm_r;
    stat[`FCS_ST_SUSP] = susp_r;
    case (HADDR[7:0])
      `FCS_OFF_CTRL: rd_mux = {28'h0000000, op_r};
      `FCS_OFF_STAT: rd_mux = stat;
      `FCS_OFF_ADDR: rd_mux = {14'h0000, addr_r};
      `FCS_OFF_WDAT: rd_mux = {16'h0000, wdat_r};
      `FCS_OFF_RDAT: rd_mux = {16'h0000, rdat_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // AHB-Lite slave, zero wait states
  // ****************************************
  always_comb begin
    wr_pend_nxt = acc && HWRITE;
    wr_off_nxt = acc ? HADDR[7:0] : wr_off_r;
    hrdata_nxt = (acc && !HWRITE) ? rd_mux : hrdata_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    if (wr_pend_r && (st_r == S_IDLE)) begin
      if (wr_off_r == `FCS_OFF_ADDR) begin
        addr_nxt = HWDATA[17:0];
      end
      if (wr_off_r == `FCS_OFF_WDAT) begin
        wdat_nxt = HWDATA[15:0];
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      wr_pend_r <= 1'b0;
      wr_off_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
      addr_r <= 18'h00000;
      wdat_r <= 16'h0000;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_off_r <= wr_off_nxt;
      hrdata_r <= hrdata_nxt;
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
    end
  end

  // ****************************************
  // Command sequence table
  // ****************************************
  always_comb begin
    s_wr = 1'b1;
    s_last = 1'b0;
    s_addr = `FCS_UNL1;
    s_data = `FCS_K_AA;
    if (idx_r == 3'h1 || idx_r == 3'h4) begin
      s_addr = `FCS_UNL2;
      s_data = `FCS_K_55;
    end
    case (op_r)
      OP_RESET: begin
        s_data = `FCS_K_F0;
        s_last = 1'b1;
      end
      OP_IDENT: begin
        if (idx_r == 3'h2) begin
          s_data = `FCS_K_90;
        end
        if (idx_r == 3'h3) begin
          s_wr = 1'b0;
          s_addr = addr_r;
          s_last = 1'b1;
        end
      end
      OP_PROG: begin
        if (idx_r == 3'h2) begin
          s_data = `FCS_K_A0;
        end
        if (idx_r == 3'h3) begin
          s_addr = addr_r;
          s_data = wdat_r;
          s_last = 1'b1;
        end
      end
      OP_BYP_ENTER: begin
        if (idx_r == 3'h2) begin
          s_data = `FCS_K_20;
          s_last = 1'b1;
        end
      end
      OP_BYP_PROG: begin
        if (idx_r == 3'h0) begin
          s_data = `FCS_K_A0;
        end else begin
          s_addr = addr_r;
          s_data = wdat_r;
          s_last = 1'b1;
        end
      end
      OP_BYP_EXIT: begin
        s_data = (idx_r == 3'h0) ? `FCS_K_90 : `FCS_K_00;
        s_last = (idx_r == 3'h1);
      end
      OP_CHIP_ERASE, OP_SECT_ERASE: begin
        if (idx_r == 3'h2) begin
          s_data = `FCS_K_80;
        end
        if (idx_r == 3'h5) begin
          s_last = 1'b1;
          if (op_r == OP_CHIP_ERASE) begin
            s_data = `FCS_K_10;
          end else begin
            s_addr = addr_r;
            s_data = `FCS_K_30;
          end
        end
      end
      OP_SUSPEND: begin
        s_data = `FCS_K_B0;
        s_last = 1'b1;
      end
      OP_RESUME: begin
        s_data = `FCS_K_30;
        s_last = 1'b1;
      end
      OP_READ: begin
        s_wr = 1'b0;
        s_addr = addr_r;
        s_last = 1'b1;
      end
      default: begin
        s_data = `FCS_K_F0;
        s_last = 1'b1;
      end
    endcase
  end

  assign poll_op = (op_r == OP_PROG) || (op_r == OP_BYP_PROG) ||
                   (op_r == OP_CHIP_ERASE) || (op_r == OP_SECT_ERASE);
  // Program polls for true data bit, erase for a one
  assign poll_exp = ((op_r == OP_PROG) || (op_r == OP_BYP_PROG)) ?
                    wdat_r[`FCS_POLL_BIT] : 1'b1;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    idx_nxt = idx_r;
    chk_nxt = chk_r;
    done_nxt = done_r;
    fail_nxt = fail_r;
    err_nxt = err_r;
    byp_nxt = byp_r;
    idm_nxt = idm_r;
    susp_nxt = susp_r;
    rdat_nxt = rdat_r;
    cyc_go = 1'b0;
    cyc_wr = 1'b0;
    cyc_addr = addr_r;
    cyc_data = `FCS_K_F0;
    case (st_r)
      S_IDLE: begin
        if (go) begin
          op_nxt = wop;
          idx_nxt = 3'h0;
          chk_nxt = 1'b0;
          done_nxt = 1'b0;
          fail_nxt = 1'b0;
          err_nxt = 1'b0;
          if (wop == OP_BYP_PROG && !byp_r) begin
            err_nxt = 1'b1;
            done_nxt = 1'b1;
          end else begin
            st_nxt = S_ISSUE;
          end
        end
      end
      S_ISSUE: begin
        // Only whole sequences are sent, never a stray cycle
        cyc_go = 1'b1;
        cyc_wr = s_wr;
        cyc_addr = s_addr;
        cyc_data = s_data;
        st_nxt = S_WAIT;
      end
      S_WAIT: begin
        if (cyc_done) begin
          if (!s_wr) begin
            rdat_nxt = cyc_rdata;
          end
          if (!s_last) begin
            idx_nxt = idx_r + 3'h1;
            st_nxt = S_ISSUE;
          end else begin
            case (op_r)
              OP_BYP_ENTER: byp_nxt = 1'b1;
              OP_BYP_EXIT: byp_nxt = 1'b0;
              OP_IDENT: idm_nxt = 1'b1;
              OP_RESET: idm_nxt = 1'b0;
              OP_SECT_ERASE: susp_nxt = 1'b0;
              OP_SUSPEND: susp_nxt = 1'b1;
              OP_RESUME: susp_nxt = 1'b0;
              default: susp_nxt = susp_r;
            endcase
            // Status is valid once the last strobe has risen
            st_nxt = poll_op ? S_POLL : S_IDLE;
            done_nxt = !poll_op;
          end
        end
      end
      S_POLL: begin
        cyc_go = 1'b1;
        st_nxt = S_PWAIT;
      end
      S_PWAIT: begin
        if (cyc_done) begin
          if (cyc_rdata[`FCS_POLL_BIT] == poll_exp) begin
            st_nxt = S_FINAL;
          end else if (chk_r) begin
            st_nxt = S_ABORT;
          end else begin
            chk_nxt = cyc_rdata[`FCS_TLIM_BIT];
            st_nxt = S_POLL;
          end
        end
      end
      S_FINAL: begin
        cyc_go = 1'b1;
        st_nxt = S_FWAIT;
      end
      S_FWAIT: begin
        if (cyc_done) begin
          rdat_nxt = cyc_rdata;
          done_nxt = 1'b1;
          st_nxt = S_IDLE;
        end
      end
      S_ABORT: begin
        cyc_go = 1'b1;
        cyc_wr = 1'b1;
        st_nxt = S_AWAIT;
      end
      S_AWAIT: begin
        if (cyc_done) begin
          fail_nxt = 1'b1;
          done_nxt = 1'b1;
          st_nxt = S_IDLE;
        end
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st_r <= S_IDLE;
      op_r <= OP_RESET;
      idx_r <= 3'h0;
      chk_r <= 1'b0;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      err_r <= 1'b0;
      byp_r <= 1'b0;
      idm_r <= 1'b0;
      susp_r <= 1'b0;
      rdat_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      idx_r <= idx_nxt;
      chk_r <= chk_nxt;
      done_r <= done_nxt;
      fail_r <= fail_nxt;
      err_r <= err_nxt;
      byp_r <= byp_nxt;
      idm_r <= idm_nxt;
      susp_r <= susp_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // ****************************************
  // Flash bus cycle engine
  // ****************************************
  fcs_cycle u_cycle (
    .clk(CLK_SYS),
    .rst(RST),
    .start(cyc_go),
    .wr(cyc_wr),
    .addr(cyc_addr),
    .wdata(cyc_data),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .fl_addr(FL_ADDR),
    .dq_o(FL_DQ_O),
    .dq_oe(FL_DQ_OE),
    .dq_i(FL_DQ_I),
    .ce_n(FL_CE_N),
    .we_n(FL_WE_N),
    .oe_n(FL_OE_N)
  );

endmodule : fcs_ctrl

// [rtl/fcs_params.svh]
// Constants of the flash command controller: map, codes, timing.
// Assumes a 125 MHz system clock and a word-mode flash device.
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH

// ****************************************
// Register map (byte offsets)
// ****************************************
`define FCS_OFF_CTRL 8'h00
`define FCS_OFF_STAT 8'h04
`define FCS_OFF_ADDR 8'h08
`define FCS_OFF_WDAT 8'h0C
`define FCS_OFF_RDAT 8'h10

// ****************************************
// Status bit positions
// ****************************************
`define FCS_ST_BUSY 0
`define FCS_ST_DONE 1
`define FCS_ST_FAIL 2
`define FCS_ST_ERR 3
`define FCS_ST_RDY 4
`define FCS_ST_BYP 5
`define FCS_ST_IDM 6
`define FCS_ST_SUSP 7

// ****************************************
// Unlock addresses and command codes
// ****************************************
`define FCS_UNL1 18'h00555
`define FCS_UNL2 18'h002AA
`define FCS_K_AA 16'h00AA
`define FCS_K_55 16'h0055
`define FCS_K_90 16'h0090
`define FCS_K_00 16'h0000
`define FCS_K_F0 16'h00F0
`define FCS_K_A0 16'h00A0
`define FCS_K_20 16'h0020
`define FCS_K_80 16'h0080
`define FCS_K_10 16'h0010
`define FCS_K_30 16'h0030
`define FCS_K_B0 16'h00B0
`define FCS_POLL_BIT 7
`define FCS_TLIM_BIT 5

// ****************************************
// Bus cycle timing
// ****************************************
`define FCS_CLK_MHZ 125
`define FCS_T_SETUP_NS 20
`define FCS_T_PULSE_NS 100
`define FCS_T_HOLD_NS 20
`define FCS_NS2CYC(ns) (((ns) * `FCS_CLK_MHZ + 999) / 1000)

`endif

// [rtl/fcs_pkg.sv]
// Types of the flash command controller.
// Assumes fcs_params.svh for the numeric constants.
package fcs_pkg;

  typedef enum logic [3:0] {
    OP_RESET = 4'h0,
    OP_IDENT = 4'h1,
    OP_PROG = 4'h2,
    OP_BYP_ENTER = 4'h3,
    OP_BYP_PROG = 4'h4,
    OP_BYP_EXIT = 4'h5,
    OP_CHIP_ERASE = 4'h6,
    OP_SECT_ERASE = 4'h7,
    OP_SUSPEND = 4'h8,
    OP_RESUME = 4'h9,
    OP_READ = 4'hA
  } fcs_op_t;

  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_ISSUE = 9'h002,
    S_WAIT = 9'h004,
    S_POLL = 9'h008,
    S_PWAIT = 9'h010,
    S_FINAL = 9'h020,
    S_FWAIT = 9'h040,
    S_ABORT = 9'h080,
    S_AWAIT = 9'h100
  } fcs_st_t;

  typedef enum logic [3:0] {
    C_IDLE = 4'h1,
    C_SET = 4'h2,
    C_PUL = 4'h4,
    C_HLD = 4'h8
  } fcs_cst_t;

endpackage : fcs_pkg

// [rtl/fcs_cycle.sv]
// One flash bus cycle, write or read, with chip select and strobes.
// Assumes read data on the data pins is synchronous to the clock.
`timescale 1ns/1ps
`include "fcs_params.svh"

module fcs_cycle #(
  parameter int SETUP_CYC = `FCS_NS2CYC(`FCS_T_SETUP_NS),
  parameter int PULSE_CYC = `FCS_NS2CYC(`FCS_T_PULSE_NS),
  parameter int HOLD_CYC = `FCS_NS2CYC(`FCS_T_HOLD_NS)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request
  input wire logic start,
  input wire logic wr,
  input wire logic [17:0] addr,
  input wire logic [15:0] wdata,
  output logic done,
  output logic [15:0] rdata,
  // Flash pins
  output logic [17:0] fl_addr,
  output logic [15:0] dq_o,
  output logic dq_oe,
  input wire logic [15:0] dq_i,
  output logic ce_n,
  output logic we_n,
  output logic oe_n
);
  import fcs_pkg::*;

  fcs_cst_t st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic wr_r, wr_nxt;
  logic done_nxt, dq_oe_nxt, ce_n_nxt, we_n_nxt, oe_n_nxt;
  logic [17:0] fl_addr_nxt;
  logic [15:0] dq_o_nxt, rdata_nxt;

  // ****************************************
  // Cycle sequencer
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    wr_nxt = wr_r;
    done_nxt = 1'b0;
    dq_oe_nxt = dq_oe;
    ce_n_nxt = ce_n;
    we_n_nxt = we_n;
    oe_n_nxt = oe_n;
    fl_addr_nxt = fl_addr;
    dq_o_nxt = dq_o;
    rdata_nxt = rdata;
    case (st_r)
      C_IDLE: begin
        if (start) begin
          // Address and data settle before any strobe falls
          wr_nxt = wr;
          fl_addr_nxt = addr;
          dq_o_nxt = wdata;
          dq_oe_nxt = wr;
          ce_n_nxt = 1'b0;
          cnt_nxt = 8'(SETUP_CYC - 1);
          st_nxt = C_SET;
        end
      end
      C_SET: begin
        if (cnt_r == 8'h00) begin
          // Chip select already low: the strobe edge is the later one
          we_n_nxt = ~wr_r;
          oe_n_nxt = wr_r;
          cnt_nxt = 8'(PULSE_CYC - 1);
          st_nxt = C_PUL;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      C_PUL: begin
        if (cnt_r == 8'h00) begin
          // Strobe rises before chip select, data still held
          we_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          if (!wr_r) begin
            rdata_nxt = dq_i;
          end
          cnt_nxt = 8'(HOLD_CYC - 1);
          st_nxt = C_HLD;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      C_HLD: begin
        if (cnt_r == 8'h00) begin
          ce_n_nxt = 1'b1;
          dq_oe_nxt = 1'b0;
          done_nxt = 1'b1;
          st_nxt = C_IDLE;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      default: begin
        st_nxt = C_IDLE;
        ce_n_nxt = 1'b1;
        we_n_nxt = 1'b1;
        oe_n_nxt = 1'b1;
        dq_oe_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= C_IDLE;
      cnt_r <= 8'h00;
      wr_r <= 1'b0;
      done <= 1'b0;
      dq_oe <= 1'b0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      fl_addr <= 18'h00000;
      dq_o <= 16'h0000;
      rdata <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
      done <= done_nxt;
      dq_oe <= dq_oe_nxt;
      ce_n <= ce_n_nxt;
      we_n <= we_n_nxt;
      oe_n <= oe_n_nxt;
      fl_addr <= fl_addr_nxt;
      dq_o <= dq_o_nxt;
      rdata <= rdata_nxt;
    end
  end

endmodule : fcs_cycle

// [sim/fcs_flash_mdl.sv]
// Behavioural word-mode flash device facing the command controller.
// Assumes the controller holds address and data across each strobe.
`timescale 1ns/1ps

module fcs_flash_mdl #(
  parameter int PROT_SEC = 5,
  parameter int BUSY_RD = 3,
  parameter logic [15:0] MFR_ID = 16'h005A // Arbitrary value
) (
  // Flash pins
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [17:0] a,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic rdy_n,
  // Fault control
  input wire logic stuck
);
  logic [15:0] mem [0:1023];
  logic [15:0] prog_val, last, rv;
  logic [17:0] la, prog_loc;
  int k, busy;
  bit wa, e80, pp, byp, bx, idm, ers, sus, tl;

  initial begin
    last = 16'h0000;
    foreach (mem[i]) mem[i] = 16'hFFFF;
  end

  // ****************************************
  // Write capture and decode
  // ****************************************
  always @(negedge we_n) if (!ce_n) la = a;
  always @(negedge ce_n) if (!we_n) la = a;
  always @(negedge we_n or negedge ce_n) wa = !we_n && !ce_n;
  always @(posedge we_n or posedge ce_n) begin
    if (wa) begin
      wa = 0;
      cmd(la, dq_in);
    end
  end

  task automatic erase(input bit all, input logic [17:0] x);
    ers = !all;
    prog_loc = x;
    prog_val = 16'hFFFF;
    busy = (!all && x[17:12] == PROT_SEC) ? 2 * BUSY_RD : BUSY_RD;
    for (int i = 0; i < 1024; i++) begin
      if ((all || i[9:4] == x[17:12]) && i[9:4] != PROT_SEC) begin
        mem[i] = 16'hFFFF;
      end
    end
  endtask : erase

  task automatic cmd(input logic [17:0] x, input logic [15:0] d);
    logic [7:0] c;
    logic [10:0] u;
    c = d[7:0];
    u = x[10:0];
    if (busy > 0) begin
      if (tl && c == 8'hF0) begin
        busy = 0;
        tl = 0;
      end else if (ers && c == 8'hB0) begin
        busy = 0;
        sus = 1;
      end
      return;
    end
    if (pp) begin
      pp = 0;
      prog_loc = x;
      prog_val = d;
      ers = 0;
      tl = stuck;
      busy = (x[17:12] == PROT_SEC) ? 1 : BUSY_RD;
      if (x[17:12] != PROT_SEC && !stuck) begin
        mem[{x[17:12], x[3:0]}] = d;
      end
      return;
    end
    if (byp) begin
      if (c == 8'hA0) pp = 1;
      else if (c == 8'h90) bx = 1;
      else if (bx && c == 8'h00) byp = 0;
      else bx = 0;
      return;
    end
    case (k)
      0: begin
        if (u == 11'h555 && c == 8'hAA) k = 1;
        else begin
          e80 = 0;
          if (c == 8'hF0) idm = 0;
          if (sus && c == 8'h30) begin
            sus = 0;
            ers = 1;
            busy = BUSY_RD;
          end
        end
      end
      1: k = (u == 11'h2AA && c == 8'h55) ? 2 : 0;
      default: begin
        k = 0;
        if (e80) begin
          e80 = 0;
          if (u == 11'h555 && c == 8'h10) erase(1'b1, x);
          if (c == 8'h30) erase(1'b0, x);
        end else if (u == 11'h555) begin
          if (c == 8'h90) idm = 1;
          if (c == 8'hA0) pp = 1;
          if (c == 8'h20) byp = 1;
          if (c == 8'h80) e80 = 1;
        end
      end
    endcase
  endtask : cmd

  // ****************************************
  // Read and status
  // ****************************************
  always_comb begin
    if (busy > 0) rv = {8'h00, ~prog_val[7], 1'b0, tl, 5'h00};
    else if (sus && a[17:12] == prog_loc[17:12]) rv = 16'h0080;
    else if (idm && a[1:0] == 2'h2) rv = {15'h0, a[17:12] == PROT_SEC};
    else if (idm) rv = MFR_ID;
    else rv = mem[{a[17:12], a[3:0]}];
  end
  always @(posedge oe_n) if (!ce_n && busy > 0 && !tl) busy = busy - 1;
  always @(negedge oe_n) #1 last = rv;
  assign dq_out = (!ce_n && !oe_n) ? rv : ~last;
  assign rdy_n = (busy == 0);
endmodule : fcs_flash_mdl

// [sim/fcs_ctrl_asserts.sv]
// Concurrent checks on the flash pins and bus response of the command controller.
// Assumes binding to fcs_ctrl; one clock domain.
`timescale 1ns/1ps

module fcs_ctrl_asserts (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Watched ports
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [17:0] FL_ADDR,
  input wire logic [15:0] FL_DQ_O,
  input wire logic FL_DQ_OE,
  input wire logic FL_CE_N,
  input wire logic FL_WE_N,
  input wire logic FL_OE_N
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  chk_ahb_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus stalled or error response");
  chk_we_in_select: assert property (!FL_WE_N |->
    !FL_CE_N && FL_OE_N && FL_DQ_OE) else $error("write strobe misuse");
  chk_read_no_drive: assert property (!FL_OE_N |->
    !FL_CE_N && !FL_DQ_OE) else $error("read cycle misuse");
  chk_write_setup: assert property ($fell(FL_WE_N) |->
    $past(!FL_CE_N, 3) && $past(FL_CE_N, 4)) else $error("bad setup");
  chk_write_pulse: assert property ($fell(FL_WE_N) |->
    ##12 !FL_WE_N ##1 FL_WE_N) else $error("bad write pulse");
  chk_write_hold: assert property ($rose(FL_WE_N) |->
    (!FL_CE_N)[*3] ##1 FL_CE_N) else $error("bad write hold");
  chk_read_pulse: assert property ($fell(FL_OE_N) |->
    ##12 !FL_OE_N ##1 FL_OE_N) else $error("bad read pulse");
  chk_addr_stable: assert property (!FL_CE_N && $past(!FL_CE_N) |->
    $stable(FL_ADDR)) else $error("address moved in cycle");
  chk_data_stable: assert property (!FL_CE_N && $past(!FL_CE_N)
    && FL_DQ_OE |-> $stable(FL_DQ_O)) else $error("data moved in cycle");
  chk_cmd_upper: assert property (!FL_WE_N &&
    FL_ADDR[10:0] inside {11'h555, 11'h2AA} |-> FL_DQ_O[15:8] == 8'h00)
    else $error("upper byte set on command");
endmodule : fcs_ctrl_asserts

bind fcs_ctrl fcs_ctrl_asserts fcs_ctrl_asserts_i (.CLK_SYS, .RST,
  .HREADYOUT, .HRESP, .FL_ADDR, .FL_DQ_O, .FL_DQ_OE, .FL_CE_N, .FL_WE_N,
  .FL_OE_N);

// [sim/fcs_ctrl_tb.sv]
// Self-checking bench: AHB register calls driving the flash controller.
// Assumes the flash model in fcs_flash_mdl.sv with sector 5 protected.
`timescale 1ns/1ps
`include "fcs_params.svh"

module fcs_ctrl_tb;
  import fcs_pkg::*;
  logic CLK_SYS, RST, HSEL, HWRITE, HREADY, HREADYOUT, HRESP, stuck;
  logic [31:0] HADDR, HWDATA, HRDATA, v;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic [17:0] FL_ADDR;
  logic [15:0] FL_DQ_O, FL_DQ_I, mdl_dq;
  logic FL_DQ_OE, FL_CE_N, FL_WE_N, FL_OE_N, FL_READY_BUSY_N;
  int n_mismatch = 0;
  int samples_checked = 0;

  assign HREADY = HREADYOUT;
  assign FL_DQ_I = FL_DQ_OE ? FL_DQ_O : mdl_dq;

  fcs_ctrl fcs_ctrl_i (.CLK_SYS, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE,
    .HSIZE, .HWDATA, .HREADY, .HREADYOUT, .HRDATA, .HRESP, .FL_ADDR,
    .FL_DQ_O, .FL_DQ_OE, .FL_DQ_I, .FL_CE_N, .FL_WE_N, .FL_OE_N,
    .FL_READY_BUSY_N);
  fcs_flash_mdl fcs_flash_mdl_i (.ce_n(FL_CE_N), .we_n(FL_WE_N),
    .oe_n(FL_OE_N), .a(FL_ADDR), .dq_in(FL_DQ_O), .dq_out(mdl_dq),
    .rdy_n(FL_READY_BUSY_N), .stuck(stuck));

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    do @(posedge CLK_SYS); while (HREADY !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge CLK_SYS); while (HREADY !== 1'b1);
    rd = HRDATA;
  endtask : bus

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic op(input fcs_op_t o, input logic [17:0] ad,
    input logic [15:0] wd, input logic [31:0] st);
    int n;
    logic [31:0] s;
    bus(1'b1, `FCS_OFF_ADDR, {14'h0, ad}, s);
    bus(1'b1, `FCS_OFF_WDAT, {16'h0, wd}, s);
    bus(1'b1, `FCS_OFF_CTRL, {28'h0, o}, s);
    n = 0;
    do begin
      bus(1'b0, `FCS_OFF_STAT, 32'h0, s);
      n++;
    end while (s[`FCS_ST_DONE] !== 1'b1 && n < 2000);
    chk(s, st);
  endtask : op

  task automatic rdat(input logic [15:0] exp);
    logic [31:0] s;
    bus(1'b0, `FCS_OFF_RDAT, 32'h0, s);
    chk(s, {16'h0, exp});
  endtask : rdat

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // ****************************************
  // Clock, watchdog, tests
  // ****************************************
  initial begin
    CLK_SYS = 1'b0;
    forever #4 CLK_SYS = ~CLK_SYS;
  end

  initial begin
    #400us;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    RST = 1'b1; HSEL = 1'b1; HSIZE = 3'h2; HTRANS = 2'h0; HADDR = '0;
    HWRITE = 1'b0; HWDATA = '0; stuck = 1'b0;
    repeat (8) @(posedge CLK_SYS);
    RST <= 1'b0;
    @(posedge CLK_SYS);
    bus(1'b0, `FCS_OFF_STAT, 32'h0, v);
    chk(v, 32'h10);
    bus(1'b1, 8'h20, 32'hFFFF_FFFF, v);
    bus(1'b0, 8'h20, 32'h0, v);
    chk(v, 32'h0);
    $display("test reset done");
    op(OP_PROG, 18'h01003, 16'h1234, 32'h12);
    rdat(16'h1234);
    op(OP_PROG, 18'h05003, 16'h00AA, 32'h12);
    rdat(16'hFFFF);
    bus(1'b0, `FCS_OFF_ADDR, 32'h0, v);
    chk(v, 32'h0000_5003);
    bus(1'b0, `FCS_OFF_WDAT, 32'h0, v);
    chk(v, 32'h0000_00AA);
    bus(1'b0, `FCS_OFF_CTRL, 32'h0, v);
    chk(v, {28'h0, OP_PROG});
    $display("test program done");
    op(OP_IDENT, 18'h05002, 16'h0, 32'h52);
    rdat(16'h0001);
    op(OP_IDENT, 18'h01002, 16'h0, 32'h52);
    rdat(16'h0000);
    op(OP_RESET, 18'h0, 16'h0, 32'h12);
    op(OP_READ, 18'h01003, 16'h0, 32'h12);
    rdat(16'h1234);
    $display("test ident done");
    op(OP_BYP_PROG, 18'h02001, 16'h00BE, 32'h1A);
    op(OP_BYP_ENTER, 18'h0, 16'h0, 32'h32);
    op(OP_RESET, 18'h0, 16'h0, 32'h32);
    op(OP_BYP_PROG, 18'h02001, 16'h00BE, 32'h32);
    rdat(16'h00BE);
    op(OP_BYP_EXIT, 18'h0, 16'h0, 32'h12);
    op(OP_READ, 18'h02001, 16'h0, 32'h12);
    rdat(16'h00BE);
    $display("test bypass done");
    op(OP_SECT_ERASE, 18'h01000, 16'h0, 32'h12);
    op(OP_READ, 18'h01003, 16'h0, 32'h12);
    rdat(16'hFFFF);
    op(OP_SUSPEND, 18'h0, 16'h0, 32'h92);
    op(OP_RESUME, 18'h0, 16'h0, 32'h12);
    op(OP_READ, 18'h02001, 16'h0, 32'h12);
    rdat(16'h00BE);
    op(OP_SECT_ERASE, 18'h05000, 16'h0, 32'h12);
    op(OP_CHIP_ERASE, 18'h0, 16'h0, 32'h12);
    op(OP_READ, 18'h02001, 16'h0, 32'h12);
    rdat(16'hFFFF);
    $display("test erase done");
    stuck <= 1'b1;
    op(OP_PROG, 18'h03004, 16'h0012, 32'h16);
    stuck <= 1'b0;
    op(OP_READ, 18'h03004, 16'h0, 32'h12);
    rdat(16'hFFFF);
    $display("test fault done");
    give_verdict();
  end
endmodule : fcs_ctrl_tb
